//--- level_ref_adc_pkg.sv
// Purpose: shared constants and types for the leveling-board converter control
// Assumes: 40 MHz system clock, synchronous active-high reset
// Notes: bus bit positions and reset images are fixed here and used everywhere
package level_ref_adc_pkg;

	// clock rate and converter clock half period
	localparam int unsigned CLK_PERIOD_PS = 25000;
	localparam int unsigned ADC_CLK_HALF_NS = 500;
	localparam int unsigned ADC_CLK_HALF_CYC_RAW = (ADC_CLK_HALF_NS * 1000) / CLK_PERIOD_PS;
	localparam int unsigned ADC_CLK_HALF_CYC = (ADC_CLK_HALF_CYC_RAW < 1) ? 1 :
		ADC_CLK_HALF_CYC_RAW;
	localparam int unsigned HALF_CNT_W = 8;
	localparam logic [HALF_CNT_W-1:0] HALF_LAST = HALF_CNT_W'(ADC_CLK_HALF_CYC - 1);

	// converter code width and bus width
	localparam int unsigned CODE_W = 10;
	localparam int unsigned BUS_W = 12;
	localparam int unsigned HOLD_W = 6;
	localparam logic [CODE_W-1:0] CODE_RESET = 10'h000;

	// converter control latch field positions on the data bus
	localparam int unsigned CTL_CONT_N_BIT = 0;
	localparam int unsigned CTL_INHIBIT_N_BIT = 1;
	localparam int unsigned CTL_CHAN_LSB = 2;
	localparam int unsigned CHAN_W = 3;
	localparam int unsigned CTL_MASK_BIT = 5;

	// completion timer: pulses allowed after the input settles inside the window
	localparam int unsigned SETTLE_PULSES = 8;
	localparam int unsigned SETTLE_W = 4;
	localparam logic [SETTLE_W-1:0] SETTLE_LAST = SETTLE_W'(SETTLE_PULSES - 1);

	// latched control bits
	typedef struct packed {
		logic continuous_convert_n;
		logic conversion_inhibit_n;
		logic [CHAN_W-1:0] input_channel_select;
		logic request_mask;
	} ctl_s;

	// reset image: not continuous, conversions inhibited, select bits low so channel 7, requests enabled
	localparam ctl_s CTL_RESET = '{
		continuous_convert_n: 1'b1,
		conversion_inhibit_n: 1'b0,
		input_channel_select: 3'h0,
		request_mask: 1'b0
	};

	// pins arriving from outside the clock domain
	typedef struct packed {
		logic level_code_write_strobe_n;
		logic sweep_code_write_strobe_n;
		logic converter_control_write_strobe_n;
		logic result_read_hold_n;
		logic detector_valid_enable;
		logic outside_window_n;
		logic [BUS_W-1:0] data_bus;
	} pins_s;

	localparam int unsigned PINS_W = $bits(pins_s);
	// idle pin image: strobes high, detector valid by pull-up, inside window
	localparam pins_s PINS_IDLE = '{
		level_code_write_strobe_n: 1'b1,
		sweep_code_write_strobe_n: 1'b1,
		converter_control_write_strobe_n: 1'b1,
		result_read_hold_n: 1'b1,
		detector_valid_enable: 1'b1,
		outside_window_n: 1'b1,
		data_bus: 12'h000
	};

endpackage : level_ref_adc_pkg

//--- pin_sync.sv
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: inputs are asynchronous to clk
// Notes: output changes only once stages two and three agree
`timescale 1ns/1ps
module pin_sync #(
	parameter int unsigned W = level_ref_adc_pkg::PINS_W,
	parameter logic [W-1:0] IDLE = '0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] pin_in,
	output logic [W-1:0] pin_out
);

	logic [W-1:0] s1_ff;
	logic [W-1:0] s2_ff;
	logic [W-1:0] s3_ff;
	logic [W-1:0] out_ff;

	// shift chain, first stage read only by the second
	always_ff @(posedge clk) begin
		if (rst) begin
			s1_ff <= IDLE;
			s2_ff <= IDLE;
			s3_ff <= IDLE;
		end else begin
			s1_ff <= pin_in;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	// per-bit agreement filter
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge clk) begin
				if (rst) begin
					out_ff[i] <= IDLE[i];
				end else if (s2_ff[i] == s3_ff[i]) begin
					out_ff[i] <= s3_ff[i];
				end
			end
		end
	endgenerate

	assign pin_out = out_ff;

endmodule : pin_sync

//--- level_ref_adc_control.sv
// Purpose: code latches, converter control latch and converter clock gating
// Assumes: all bus pins and strobes are asynchronous and pass the pin synchroniser
// Notes: the free-running RC oscillator is modelled as a divider on clk
// Notes: every pin reaches the logic four to five clk cycles late, so the host
//   must hold strobes and data for at least five cycles on each side of an edge
// Notes: outside_window_n is low while the converter input sits outside the
//   window, which is what starts a conversion; inside the window the timer counts
// Notes: the converter clock always stops with its output high, so a restart
//   begins with a low half, though a disable during a low half cuts that low pulse short
// Notes: code latches take the bus as it stood just before the strobe rose
// Notes: the self-test failure indicator is driven by the processor, not here
//
// What this block does
// R1: level reference code is ten bits, one step is 1/1024 of reference.
// R2: level code captured from data bus by the level write strobe.
// R3: power sweep code has its own latch, same behaviour as level code.
// R4: processor alone switches the self-test failure indicator on and off.
// R5: control latch takes six bus bits when control strobe goes low.
// R6: bits: continuous-convert low, inhibit low, three select low, mask high.
// R7: converter clock runs only with all three enables high, else held high.
// R8: converter clock held disabled while the processor reads the result.
// R9: rising clock at conversion end advances timer; terminal count flags completion.
// R10: clock disabled before next falling edge once completion is flagged.
// R11: latched inhibit low stops the converter clock.
// R12: continuous-convert low enables clock regardless of completion or detector.
// R13: else clock off when run latch reset or detector-valid low.
// R14: detector-valid input high only for valid level; idles high when absent.
// R15: three select bits pick one of eight analog channels.
// R16: channel zero carries detected level, bipolar unity gain.
// R17: channels one to five carry health voltages, offset into converter span.
// R18: channel six carries the modulator level for peaking feedback.
// R19: channel seven is a test point for checking the converter.
// R20: after input enters window clock runs eight more pulses then stops.
// R21: request mask high keeps completion from asserting the service request.
`timescale 1ns/1ps
module level_ref_adc_control (
	input wire logic clk,
	input wire logic rst,
	input wire logic [level_ref_adc_pkg::BUS_W-1:0] data_bus,
	input wire logic level_code_write_strobe_n,
	input wire logic sweep_code_write_strobe_n,
	input wire logic converter_control_write_strobe_n,
	input wire logic result_read_hold_n,
	input wire logic detector_valid_enable,
	input wire logic outside_window_n,
	output logic [level_ref_adc_pkg::CODE_W-1:0] level_code,
	output logic [level_ref_adc_pkg::CODE_W-1:0] power_sweep_code,
	output logic [level_ref_adc_pkg::CHAN_W-1:0] input_channel_select,
	output logic converter_clk,
	output logic service_request_n,
	output logic terminal_count_out,
	output logic conversion_running
);

	typedef enum logic [1:0] {
		OSC_STOPPED,
		OSC_LOW,
		OSC_HIGH
	} osc_e;

	level_ref_adc_pkg::pins_s pins_raw;
	level_ref_adc_pkg::pins_s pins;
	level_ref_adc_pkg::pins_s pins_prev_ff;
	level_ref_adc_pkg::ctl_s ctl_ff;
	level_ref_adc_pkg::ctl_s nxt_ctl;
	logic [level_ref_adc_pkg::CODE_W-1:0] level_code_ff;
	logic [level_ref_adc_pkg::CODE_W-1:0] sweep_code_ff;
	logic [level_ref_adc_pkg::CHAN_W-1:0] chan_ff;
	logic level_write_done;
	logic sweep_write_done;
	logic ctl_write_start;
	logic read_start;
	logic clk_enable;
	logic continuous_term;
	logic gated_term;
	osc_e osc_ff;
	osc_e nxt_osc;
	logic [level_ref_adc_pkg::HALF_CNT_W-1:0] half_cnt_ff;
	logic half_done;
	logic conv_clk_rise;
	logic conv_clk_ff;
	logic [level_ref_adc_pkg::SETTLE_W-1:0] settle_cnt_ff;
	logic settle_terminal;
	logic tc_ff;
	logic run_ff;
	logic srq_n_ff;

	// gather the pins into one bundle
	assign pins_raw = '{
		level_code_write_strobe_n: level_code_write_strobe_n,
		sweep_code_write_strobe_n: sweep_code_write_strobe_n,
		converter_control_write_strobe_n: converter_control_write_strobe_n,
		result_read_hold_n: result_read_hold_n,
		detector_valid_enable: detector_valid_enable,
		outside_window_n: outside_window_n,
		data_bus: data_bus
	};

	// every pin crosses into clk through three stages
	// the bus and strobes share one bundle so all bits see the same delay;
	// a bit only moves once stages two and three agree, which rejects a
	// single-cycle glitch on a strobe line
	pin_sync #(
		.W(level_ref_adc_pkg::PINS_W),
		.IDLE(level_ref_adc_pkg::PINS_IDLE)
	) u_pin_sync (
		.clk(clk),
		.rst(rst),
		.pin_in(pins_raw),
		.pin_out(pins)
	);

	// previous filtered pin image for edge detection
	always_ff @(posedge clk) begin
		if (rst) begin
			pins_prev_ff <= level_ref_adc_pkg::PINS_IDLE;
		end else begin
			pins_prev_ff <= pins;
		end
	end

	// strobe edges: code latches take data at the end of the strobe
	// all four edge detectors start from the idle image, so no false edge after reset;
	// the code latches read the previous bus image, the value that stood while
	// the strobe was still low, so a bus released at the rising edge is harmless
	assign level_write_done = pins.level_code_write_strobe_n &
		~pins_prev_ff.level_code_write_strobe_n;
	assign sweep_write_done = pins.sweep_code_write_strobe_n &
		~pins_prev_ff.sweep_code_write_strobe_n;
	assign ctl_write_start = ~pins.converter_control_write_strobe_n &
		pins_prev_ff.converter_control_write_strobe_n; // R5
	assign read_start = ~pins.result_read_hold_n & pins_prev_ff.result_read_hold_n;

	// level reference code, all ten bits from the bus in one write
	always_ff @(posedge clk) begin
		if (rst) begin
			level_code_ff <= level_ref_adc_pkg::CODE_RESET;
		end else if (level_write_done) begin
			level_code_ff <= pins_prev_ff.data_bus[level_ref_adc_pkg::CODE_W-1:0]; // R1 R2
		end
	end

	// power sweep code, separate latch with identical behaviour
	always_ff @(posedge clk) begin
		if (rst) begin
			sweep_code_ff <= level_ref_adc_pkg::CODE_RESET;
		end else if (sweep_write_done) begin
			sweep_code_ff <= pins_prev_ff.data_bus[level_ref_adc_pkg::CODE_W-1:0]; // R3
		end
	end

	// decode the six control bits from the bus
	always_comb begin
		nxt_ctl = ctl_ff;
		if (ctl_write_start) begin
			nxt_ctl.continuous_convert_n =
				pins.data_bus[level_ref_adc_pkg::CTL_CONT_N_BIT]; // R6
			nxt_ctl.conversion_inhibit_n =
				pins.data_bus[level_ref_adc_pkg::CTL_INHIBIT_N_BIT]; // R6
			nxt_ctl.input_channel_select = pins.data_bus[
				level_ref_adc_pkg::CTL_CHAN_LSB +: level_ref_adc_pkg::CHAN_W]; // R6
			nxt_ctl.request_mask = pins.data_bus[level_ref_adc_pkg::CTL_MASK_BIT]; // R6
		end
	end

	// converter control latch
	always_ff @(posedge clk) begin
		if (rst) begin
			ctl_ff <= level_ref_adc_pkg::CTL_RESET;
		end else begin
			ctl_ff <= nxt_ctl; // R5
		end
	end

	// channel select drives the analog multiplexer; select bits are active low
	// taken from nxt_ctl so the multiplexer moves in the same cycle as the latch
	always_ff @(posedge clk) begin
		if (rst) begin
			chan_ff <= ~level_ref_adc_pkg::CTL_RESET.input_channel_select;
		end else begin
			chan_ff <= ~nxt_ctl.input_channel_select; // R15 R16 R17 R18 R19
		end
	end

	// clock enable terms: read hold, inhibit, continuous or gated
	assign continuous_term = ~ctl_ff.continuous_convert_n; // R12
	assign gated_term = run_ff & pins.detector_valid_enable; // R13 R14
	assign clk_enable = pins.result_read_hold_n // R8
		& ctl_ff.conversion_inhibit_n // R11
		& (continuous_term | gated_term); // R7

	// half period divider stands in for the rc timing
	// the count is cleared whenever the clock is disabled, so every restart
	// yields a low half one clk cycle shorter than a full half period; the rc original tolerates 2:1 drift, so
	// the exact half period is a free choice of the package
	assign half_done = (half_cnt_ff == level_ref_adc_pkg::HALF_LAST);

	always_ff @(posedge clk) begin
		if (rst) begin
			half_cnt_ff <= '0;
		end else if (!clk_enable || half_done) begin
			half_cnt_ff <= '0;
		end else begin
			half_cnt_ff <= half_cnt_ff + 1'b1;
		end
	end

	// oscillator state: stopped high, low half, high half
	// terminal count arrives on a rising edge, so the machine goes straight from
	// the low half to stopped: the output rises and stays high, and no falling
	// edge can follow the completion
	always_comb begin
		nxt_osc = osc_ff;
		unique case (osc_ff)
			OSC_STOPPED: begin
				if (clk_enable) begin
					nxt_osc = OSC_LOW; // output falls at once on enable
				end
			end
			OSC_LOW: begin
				if (!clk_enable) begin
					nxt_osc = OSC_STOPPED;
				end else if (half_done && settle_terminal) begin
					nxt_osc = OSC_STOPPED; // R10
				end else if (half_done) begin
					nxt_osc = OSC_HIGH;
				end
			end
			OSC_HIGH: begin
				if (!clk_enable) begin
					nxt_osc = OSC_STOPPED;
				end else if (half_done) begin
					nxt_osc = OSC_LOW;
				end
			end
			default: begin
				nxt_osc = OSC_STOPPED; // unused code parks the clock high
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			osc_ff <= OSC_STOPPED;
		end else begin
			osc_ff <= nxt_osc;
		end
	end

	// converter clock output, high whenever stopped
	always_ff @(posedge clk) begin
		if (rst) begin
			conv_clk_ff <= 1'b1;
		end else begin
			conv_clk_ff <= (nxt_osc != OSC_LOW); // R7
		end
	end

	// one-cycle pulse on each rising edge of the converter clock, except a rise forced by a disable
	assign conv_clk_rise = (osc_ff == OSC_LOW) && clk_enable && half_done;

	// terminal count reached on this rising edge
	assign settle_terminal = conv_clk_rise && pins.outside_window_n
		&& (settle_cnt_ff == level_ref_adc_pkg::SETTLE_LAST)
		&& ctl_ff.continuous_convert_n; // R20

	// completion timer counts rising edges while inside the window
	// leaving the window drops a partial count, so eight fresh pulses follow
	always_ff @(posedge clk) begin
		if (rst) begin
			settle_cnt_ff <= '0;
		end else if (!pins.outside_window_n) begin
			settle_cnt_ff <= '0; // outside: converter still tracking
		end else if (conv_clk_rise) begin
			if (settle_cnt_ff == level_ref_adc_pkg::SETTLE_LAST) begin
				settle_cnt_ff <= '0; // reload after terminal count
			end else begin
				settle_cnt_ff <= settle_cnt_ff + 1'b1; // R9 R20
			end
		end
	end

	// terminal count pulse toward the processor side
	always_ff @(posedge clk) begin
		if (rst) begin
			tc_ff <= 1'b0;
		end else begin
			tc_ff <= settle_terminal; // R9
		end
	end

	// run latch: set when input leaves the window, cleared at terminal count
	// terminal count only fires inside the window, so set and clear never meet
	always_ff @(posedge clk) begin
		if (rst) begin
			run_ff <= 1'b0;
		end else if (!pins.outside_window_n) begin
			run_ff <= 1'b1; // outside window starts a conversion
		end else if (settle_terminal) begin
			run_ff <= 1'b0; // R13 R20
		end
	end

	// service request: completion sets it low, a result read releases it
	// completion wins over a read starting in the same cycle, so a finished
	// conversion is never lost; the mask only blocks new requests and leaves
	// one already standing until the processor reads the result
	always_ff @(posedge clk) begin
		if (rst) begin
			srq_n_ff <= 1'b1;
		end else if (settle_terminal && !ctl_ff.request_mask) begin
			srq_n_ff <= 1'b0; // R9 R21
		end else if (read_start) begin
			srq_n_ff <= 1'b1;
		end
	end

	// outputs straight from flip-flops
	assign level_code = level_code_ff;
	assign power_sweep_code = sweep_code_ff;
	assign input_channel_select = chan_ff;
	assign converter_clk = conv_clk_ff;
	assign service_request_n = srq_n_ff;
	assign terminal_count_out = tc_ff;
	assign conversion_running = run_ff;

endmodule : level_ref_adc_control

//--- level_ref_adc_control_assertions.sv
// Purpose: port-level checks on converter clock, completion and service request
// Assumes: single clk domain, synchronous active-high reset
// Notes: pins pass a synchroniser, so pin-caused waits allow a few cycles
`timescale 1ns/1ps
module level_ref_adc_control_assertions (
	input wire logic clk,
	input wire logic rst,
	input wire logic result_read_hold_n,
	input wire logic converter_clk,
	input wire logic service_request_n,
	input wire logic terminal_count_out,
	input wire logic conversion_running
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// idle image at first edge after reset
	a_reset_idle_image: assert property ($fell(rst) |-> converter_clk && service_request_n
		&& !terminal_count_out && !conversion_running) else $error("outputs not idle after reset");
	// read hold keeps the clock high
	a_read_hold_stops: assert property (!result_read_hold_n [*8] |-> converter_clk)
		else $error("converter clock low during read hold");
	// completion is a single pulse
	a_tc_single_pulse: assert property (terminal_count_out |=> !terminal_count_out)
		else $error("terminal count longer than one cycle");
	// request only falls at completion
	a_srq_after_tc: assert property ($fell(service_request_n) |->
		terminal_count_out || $past(terminal_count_out)) else $error("request without completion");
	// completion stops the clock high
	a_tc_stops_clock: assert property (terminal_count_out |->
		converter_clk && !conversion_running) else $error("clock not stopped at completion");
	// read start releases the request
	a_read_clears_srq: assert property ($fell(result_read_hold_n) |-> ##[1:8] service_request_n)
		else $error("request not released by read");
	// low phase of the clock is bounded
	a_low_phase_bound: assert property ($fell(converter_clk) |-> ##[1:21] converter_clk)
		else $error("converter clock low too long");
	// run latch only ends at completion
	a_run_ends_tc: assert property ($fell(conversion_running) |->
		terminal_count_out || $past(terminal_count_out)) else $error("run cleared early");
endmodule : level_ref_adc_control_assertions

//--- host_proc_model.sv
// Purpose: host processor and neighbour boards driving the control pins
// Assumes: pins change just after falling clk edges
// Notes: a released bus shows the inverse of the last write
`timescale 1ns/1ps
module host_proc_model (
	input wire logic clk,
	output level_ref_adc_pkg::pins_s pins
);
	// idle: strobes high, detector valid by pull-up, inside window
	initial pins = level_ref_adc_pkg::PINS_IDLE;

	// strobed write: 0 level code, 1 sweep code, 2 control latch
	task automatic wr(input int sel, input logic [11:0] d);
		@(negedge clk);
		pins.data_bus = d;
		pins.level_code_write_strobe_n = (sel != 0);
		pins.sweep_code_write_strobe_n = (sel != 1);
		pins.converter_control_write_strobe_n = (sel != 2);
		repeat (6) @(negedge clk);
		pins.level_code_write_strobe_n = 1'h1;
		pins.sweep_code_write_strobe_n = 1'h1;
		pins.converter_control_write_strobe_n = 1'h1;
		repeat (6) @(negedge clk);
		pins.data_bus = ~d; // bus released
	endtask : wr

	// self-test failure indicator belongs to the processor; no pin reaches the block
	// read hold, detector valid and window lines
	task automatic lines(input logic hold_n, input logic det, input logic win_n);
		@(negedge clk);
		pins.result_read_hold_n = hold_n;
		pins.detector_valid_enable = det;
		pins.outside_window_n = win_n;
	endtask : lines
endmodule : host_proc_model

//--- level_ref_adc_control_tb_top.sv
// Purpose: self-checking bench for the converter control block
// Assumes: host model drives all pins at falling clk edges
// Notes: drivers queue expectations, a monitor compares on each note
`timescale 1ns/1ps
module level_ref_adc_control_tb_top;
	typedef struct packed {
		logic [2:0] sel;
		logic [9:0] v;
	} note_s;
	localparam logic lo = 1'h0;
	localparam logic hi = 1'h1;
	logic clk;
	logic rst;
	level_ref_adc_pkg::pins_s pins;
	logic [9:0] level_code;
	logic [9:0] power_sweep_code;
	logic [2:0] input_channel_select;
	logic converter_clk;
	logic service_request_n;
	logic terminal_count_out;
	logic conversion_running;
	note_s notes[$];
	note_s n;
	event seen;
	int bad_count;
	int checked;
	int rises;
	int falls;
	int tc_seen;
	logic [9:0] meas;
	logic [11:0] d;

	host_proc_model i_host (.clk(clk), .pins(pins));
	level_ref_adc_control i_dut (
		.clk(clk),
		.rst(rst),
		.data_bus(pins.data_bus),
		.level_code_write_strobe_n(pins.level_code_write_strobe_n),
		.sweep_code_write_strobe_n(pins.sweep_code_write_strobe_n),
		.converter_control_write_strobe_n(pins.converter_control_write_strobe_n),
		.result_read_hold_n(pins.result_read_hold_n),
		.detector_valid_enable(pins.detector_valid_enable),
		.outside_window_n(pins.outside_window_n),
		.level_code(level_code),
		.power_sweep_code(power_sweep_code),
		.input_channel_select(input_channel_select),
		.converter_clk(converter_clk),
		.service_request_n(service_request_n),
		.terminal_count_out(terminal_count_out),
		.conversion_running(conversion_running)
	);

	// 40 MHz clock
	initial begin
		clk = 1'h0;
		forever #12.5 clk = ~clk;
	end

	task automatic check(input string what, input logic [9:0] got, input logic [9:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : complete_run

	task automatic note(input logic [2:0] s, input logic [9:0] v);
		notes.push_back('{s, v});
		#1 ->seen;
		#1;
	endtask : note

	// control word: random spare bits, mask, select low-active, inhibit, continuous
	function automatic logic [11:0] ctl(input logic cont_n, input logic inh_n,
		input logic [2:0] ch, input logic mask);
		return {6'($urandom), mask, ~ch, inh_n, cont_n};
	endfunction : ctl

	// count clock edges over a span, optionally until a completion pulse
	task automatic watch(input int span, input bit stop_tc);
		logic prev;
		rises = 0;
		falls = 0;
		tc_seen = 0;
		prev = converter_clk;
		repeat (span) begin
			@(negedge clk);
			rises += int'(!prev && converter_clk);
			falls += int'(prev && !converter_clk);
			tc_seen += int'(terminal_count_out);
			prev = converter_clk;
			if (stop_tc && tc_seen > 0)
				break;
		end
	endtask : watch

	// monitor: compare oldest note with the output it names
	initial forever begin
		@(seen);
		n = notes.pop_front();
		case (n.sel)
			3'h0: check("level_code", level_code, n.v);
			3'h1: check("power_sweep_code", power_sweep_code, n.v);
			3'h2: check("input_channel_select", {7'h0, input_channel_select}, n.v);
			3'h3: check("converter_clk", {9'h0, converter_clk}, n.v);
			3'h4: check("service_request_n", {9'h0, service_request_n}, n.v);
			default: check("measured", meas, n.v);
		endcase
	end

	// watchdog
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		complete_run();
	end

	initial begin
		void'($urandom(98794));
		rst = 1'h1;
		repeat (5) @(negedge clk);
		rst = 1'h0;
		repeat (4) @(negedge clk);
		note(3'h3, 10'h1);
		note(3'h4, 10'h1);
		note(3'h2, 10'h7);
		note(3'h0, 10'h0);
		// extremes then random codes, level code rechecked after each sweep write
		for (int i = 0; i < 4; i++) begin
			d = (i == 0) ? 12'hfff : (i == 1) ? 12'h000 : 12'($urandom);
			i_host.wr(0, d);
			note(3'h0, d[9:0]);
			i_host.wr(1, ~d);
			note(3'h1, ~d[9:0]);
			note(3'h0, d[9:0]);
		end
		// every channel while inhibited
		for (int ch = 0; ch < 8; ch++) begin
			i_host.wr(2, ctl(hi, lo, 3'(ch), lo));
			note(3'h2, 10'(ch));
		end
		i_host.wr(2, ctl(lo, lo, 3'h0, lo));
		watch(120, 0);
		meas = 10'(falls);
		note(3'h7, 10'h0);
		i_host.lines(hi, lo, hi);
		i_host.wr(2, ctl(lo, hi, 3'h0, lo));
		watch(200, 0);
		meas = 10'(falls >= 4);
		note(3'h7, 10'h1);
		i_host.lines(lo, lo, hi);
		repeat (25) @(negedge clk);
		watch(120, 0);
		meas = 10'(falls);
		note(3'h7, 10'h0);
		i_host.wr(2, ctl(hi, hi, 3'h6, lo));
		i_host.lines(hi, lo, lo);
		watch(120, 0);
		meas = 10'(falls);
		note(3'h7, 10'h0);
		// completion with request enabled, then masked
		for (int m = 0; m < 2; m++) begin
			i_host.wr(2, ctl(hi, hi, 3'h6, m[0]));
			i_host.lines(hi, hi, lo);
			watch(200, 0);
			i_host.lines(hi, hi, hi);
			watch(600, 1);
			meas = 10'(rises >= 8 && rises <= 9 && tc_seen == 1);
			note(3'h7, 10'h1);
			repeat (3) @(negedge clk);
			note(3'h4, {9'h0, m[0]});
			watch(100, 0);
			meas = 10'(falls);
			note(3'h7, 10'h0);
			i_host.lines(lo, hi, hi);
			repeat (10) @(negedge clk);
			note(3'h4, 10'h1);
			i_host.lines(hi, hi, hi);
		end
		repeat (5) @(negedge clk);
		complete_run();
	end
endmodule : level_ref_adc_control_tb_top

bind level_ref_adc_control level_ref_adc_control_assertions i_chk (
	.clk(clk),
	.rst(rst),
	.result_read_hold_n(result_read_hold_n),
	.converter_clk(converter_clk),
	.service_request_n(service_request_n),
	.terminal_count_out(terminal_count_out),
	.conversion_running(conversion_running)
);
